/* rtl/rffq_regs.v */
// Purpose: frequency plan and fifo register group behind the serial register bus
// Assumes: sclk, sdi, chip_select_n from pins; afc, fifo status from same-clock logic
// Notes: fifo storage lives outside; this block issues push and pop strobes
// Behaviour
// RQ1: 10-bit signed offset, top two in high register
// RQ2: offset equals 156.25 Hz times band factor
// RQ3: offset register reads return last correction result
// RQ4: high band flag picks upper range
// RQ5: band index steps 10 or 20 MHz
// RQ6: carrier kHz from band, word, offset, hop
// RQ7: carrier word high byte first address
// RQ8: hop channel multiplies step size
// RQ9: hop step in 10 kHz, resets zero
// RQ10: tx nearly-full level, reset 0x37
// RQ11: tx nearly-empty level in bits 5:0
// RQ12: rx nearly-full level in bits 5:0
// RQ13: fifo port write bursts into tx fifo
// RQ14: host ends burst by raising select
// RQ15: fifo port read bursts from rx fifo
// RQ16: band select resets 0x75, top bit reserved
// RQ17: serial data sampled on rising clock
// RQ18: select frames every access and burst
// RQ19: occupancy compared against each level, raises flags
// RQ20: empty read or full write changes nothing
`timescale 1ns/100ps
`include "rffq_consts.vh"
module rffq_regs (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire sclk,
  input wire sdi,
  input wire chip_select_n,
  output reg sdo,
  output reg sdo_oe,
  input wire [9:0] auto_freq_correction,
  input wire [6:0] tx_fifo_count,
  input wire tx_fifo_full,
  input wire [6:0] rx_fifo_count,
  input wire rx_fifo_empty,
  input wire [7:0] rx_fifo_data,
  output reg tx_fifo_push,
  output reg [7:0] tx_fifo_data,
  output reg rx_fifo_pop,
  output reg tx_nearly_full,
  output reg tx_nearly_empty,
  output reg rx_nearly_full,
  output reg high_band,
  output reg sideband,
  output reg [9:0] band_start_mhz,
  output reg signed [10:0] offset_steps,
  output reg [23:0] carrier_khz
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function [23:0] mul24;
  input [23:0] a;
  input [23:0] b;
  reg [47:0] p;
  begin
    p = a * b;
    mul24 = p[23:0];
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire [2:0] pin_sync;
wire [2:0] pin_prev;

rffq_sync #(
  .WIDTH(3)
) u_sync (
  .clk(clk),
  .reset(reset),
  .ce(ce),
  .async_in({chip_select_n, sclk, sdi}),
  .reset_value(3'h4),
  .sync_out(pin_sync),
  .sync_prev(pin_prev)
);

wire sel_active = ~pin_sync[2];
wire sclk_rise = pin_sync[1] & ~pin_prev[1]; // RQ17
wire sclk_fall = ~pin_sync[1] & pin_prev[1];
wire sdi_bit = pin_sync[0];

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] offset_low_reg;
reg [1:0] offset_high_reg;
reg [6:0] band_select_reg;
reg [7:0] carrier_high_reg;
reg [7:0] carrier_low_reg;
reg [7:0] hop_channel_reg;
reg [7:0] hop_step_reg;
reg [7:0] tx_full_level_reg;
reg [7:0] tx_empty_level_reg;
reg [7:0] rx_full_level_reg;

// serial frame state
reg [2:0] bit_count_reg;
reg [7:0] shift_in_reg;
reg [7:0] shift_out_reg;
reg have_addr_reg;
reg write_dir_reg;
reg [6:0] addr_reg;
reg pop_pending_reg;

wire [7:0] byte_in = {shift_in_reg[6:0], sdi_bit};
wire byte_done = sel_active & sclk_rise & (bit_count_reg == `RFFQ_BITS_PER_BYTE);
wire [9:0] freq_offset_word = {offset_high_reg, offset_low_reg}; // RQ1
wire [15:0] carrier_fraction = {carrier_high_reg, carrier_low_reg}; // RQ7
wire [4:0] band_index = band_select_reg[`RFFQ_BAND_MSB:0];
wire hb = band_select_reg[`RFFQ_HIGHBAND_BIT];

// address of the byte being loaded: the header names it, later bytes the next address, or the fifo port again
wire [6:0] addr_next = (addr_reg == `RFFQ_ADDR_FIFO_PORT) ? addr_reg : addr_reg + 7'h01;
wire [6:0] rd_addr = have_addr_reg ? addr_next : byte_in[6:0];
wire rd_start = byte_done & (have_addr_reg ? ~write_dir_reg : ~byte_in[`RFFQ_DIR_BIT]);
wire rd_fifo = rd_start & (rd_addr == `RFFQ_ADDR_FIFO_PORT);
wire wr_byte = byte_done & have_addr_reg & write_dir_reg;

////////////////////////////////////////////////////////////////////////////////
// read mux

reg [7:0] rd_data;

always @*
begin
  case (rd_addr)
    `RFFQ_ADDR_OFFSET_LOW: rd_data = auto_freq_correction[7:0]; // RQ3
    `RFFQ_ADDR_OFFSET_HIGH: rd_data = {6'h00, auto_freq_correction[9:8]}; // RQ3
    `RFFQ_ADDR_BAND_SELECT: rd_data = {1'b0, band_select_reg}; // RQ16
    `RFFQ_ADDR_CARRIER_HIGH: rd_data = carrier_high_reg;
    `RFFQ_ADDR_CARRIER_LOW: rd_data = carrier_low_reg;
    `RFFQ_ADDR_HOP_CHANNEL: rd_data = hop_channel_reg;
    `RFFQ_ADDR_HOP_STEP: rd_data = hop_step_reg;
    `RFFQ_ADDR_TX_FULL_LEVEL: rd_data = tx_full_level_reg;
    `RFFQ_ADDR_TX_EMPTY_LEVEL: rd_data = tx_empty_level_reg;
    `RFFQ_ADDR_RX_FULL_LEVEL: rd_data = rx_full_level_reg;
    `RFFQ_ADDR_FIFO_PORT: rd_data = rx_fifo_empty ? 8'h00 : rx_fifo_data; // RQ15 RQ20
    default: rd_data = 8'h00;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// serial engine

always @(posedge clk)
begin
  if (reset)
  begin
    bit_count_reg <= 3'h0;
    shift_in_reg <= 8'h00;
    shift_out_reg <= 8'h00;
    have_addr_reg <= 1'b0;
    write_dir_reg <= 1'b0;
    addr_reg <= 7'h00;
    sdo <= 1'b0;
    sdo_oe <= 1'b0;
    rx_fifo_pop <= 1'b0;
    pop_pending_reg <= 1'b0;
  end
  else if (ce)
  begin
    rx_fifo_pop <= 1'b0;
    sdo_oe <= sel_active;
    if (!sel_active)
    begin
      // select high closes the access or burst
      bit_count_reg <= 3'h0; // RQ14 RQ18
      have_addr_reg <= 1'b0;
      sdo <= 1'b0;
      pop_pending_reg <= 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        bit_count_reg <= bit_count_reg + 3'h1;
        shift_in_reg <= byte_in;
        if (bit_count_reg == 3'h0 && pop_pending_reg)
        begin
          // loaded fifo byte starts to leave, so release it; an unread one stays
          rx_fifo_pop <= 1'b1; // RQ15 RQ20
          pop_pending_reg <= 1'b0;
        end
      end
      if (byte_done)
      begin
        if (!have_addr_reg)
        begin
          have_addr_reg <= 1'b1;
          write_dir_reg <= byte_in[`RFFQ_DIR_BIT];
          addr_reg <= byte_in[6:0];
        end
        else if (addr_reg != `RFFQ_ADDR_FIFO_PORT)
        begin
          addr_reg <= addr_reg + 7'h01; // RQ13 RQ15
        end
      end
      if (rd_start)
      begin
        sdo <= rd_data[7];
        shift_out_reg <= {rd_data[6:0], 1'b0};
        pop_pending_reg <= rd_fifo & ~rx_fifo_empty; // RQ15 RQ20
      end
      else if (sclk_fall && bit_count_reg != 3'h0)
      begin
        sdo <= shift_out_reg[7];
        shift_out_reg <= {shift_out_reg[6:0], 1'b0};
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// register writes

always @(posedge clk)
begin
  if (reset)
  begin
    offset_low_reg <= `RFFQ_RST_OFFSET_LOW;
    offset_high_reg <= `RFFQ_RST_OFFSET_HIGH;
    band_select_reg <= `RFFQ_RST_BAND_SELECT; // RQ16
    carrier_high_reg <= `RFFQ_RST_CARRIER_HIGH;
    carrier_low_reg <= `RFFQ_RST_CARRIER_LOW;
    hop_channel_reg <= `RFFQ_RST_HOP_CHANNEL;
    hop_step_reg <= `RFFQ_RST_HOP_STEP; // RQ9
    tx_full_level_reg <= `RFFQ_RST_TX_FULL_LEVEL; // RQ10
    tx_empty_level_reg <= `RFFQ_RST_TX_EMPTY_LEVEL;
    rx_full_level_reg <= `RFFQ_RST_RX_FULL_LEVEL;
    tx_fifo_push <= 1'b0;
    tx_fifo_data <= 8'h00;
  end
  else if (ce)
  begin
    tx_fifo_push <= 1'b0;
    if (wr_byte)
    begin
      case (addr_reg)
        `RFFQ_ADDR_OFFSET_LOW: offset_low_reg <= byte_in;
        `RFFQ_ADDR_OFFSET_HIGH: offset_high_reg <= byte_in[1:0]; // RQ1
        `RFFQ_ADDR_BAND_SELECT: band_select_reg <= byte_in[6:0]; // RQ16
        `RFFQ_ADDR_CARRIER_HIGH: carrier_high_reg <= byte_in; // RQ7
        `RFFQ_ADDR_CARRIER_LOW: carrier_low_reg <= byte_in; // RQ7
        `RFFQ_ADDR_HOP_CHANNEL: hop_channel_reg <= byte_in; // RQ8
        `RFFQ_ADDR_HOP_STEP: hop_step_reg <= byte_in; // RQ9
        `RFFQ_ADDR_TX_FULL_LEVEL: tx_full_level_reg <= byte_in; // RQ10
        `RFFQ_ADDR_TX_EMPTY_LEVEL: tx_empty_level_reg <= byte_in; // RQ11
        `RFFQ_ADDR_RX_FULL_LEVEL: rx_full_level_reg <= byte_in; // RQ12
        `RFFQ_ADDR_FIFO_PORT:
        begin
          tx_fifo_push <= ~tx_fifo_full; // RQ13 RQ20
          tx_fifo_data <= byte_in;
        end
        default: offset_low_reg <= offset_low_reg;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// frequency plan arithmetic

wire [17:0] frac_sum = {2'h0, carrier_fraction} + {{8{freq_offset_word[9]}}, freq_offset_word};
wire signed [23:0] frac_ext = {{6{frac_sum[17]}}, frac_sum};
wire signed [23:0] frac_scaled = hb ? (frac_ext * (`RFFQ_FRAC_MUL * 24'sh000002)) : (frac_ext * `RFFQ_FRAC_MUL);
wire signed [23:0] frac_khz = frac_scaled >>> `RFFQ_FRAC_SHIFT;
wire [23:0] band_khz = mul24({19'h00000, band_index} + `RFFQ_BAND_BASE,
  hb ? (`RFFQ_BAND_KHZ << 1) : `RFFQ_BAND_KHZ);
wire [23:0] hop_khz = mul24(mul24({16'h0000, hop_channel_reg}, {16'h0000, hop_step_reg}), `RFFQ_HOP_UNIT_KHZ);
wire [9:0] band_step = hb ? `RFFQ_HIGH_STEP_MHZ : `RFFQ_LOW_STEP_MHZ;
wire [9:0] band_base = hb ? `RFFQ_HIGH_START_MHZ : `RFFQ_LOW_START_MHZ;
wire [23:0] band_mhz_wide = mul24({19'h00000, band_index}, {14'h0000, band_step});

always @(posedge clk)
begin
  if (reset)
  begin
    high_band <= 1'b0;
    sideband <= 1'b0;
    band_start_mhz <= 10'h000;
    offset_steps <= 11'h000;
    carrier_khz <= 24'h000000;
    tx_nearly_full <= 1'b0;
    tx_nearly_empty <= 1'b0;
    rx_nearly_full <= 1'b0;
  end
  else if (ce)
  begin
    high_band <= hb; // RQ4
    sideband <= band_select_reg[`RFFQ_SIDEBAND_BIT];
    band_start_mhz <= band_base + band_mhz_wide[9:0]; // RQ5
    offset_steps <= hb ? {freq_offset_word, 1'b0} : {freq_offset_word[9], freq_offset_word}; // RQ2
    carrier_khz <= band_khz + frac_khz + hop_khz; // RQ6 RQ8
    tx_nearly_full <= tx_fifo_count >= {1'b0, tx_full_level_reg[`RFFQ_LEVEL_MSB:0]}; // RQ19
    tx_nearly_empty <= tx_fifo_count <= {1'b0, tx_empty_level_reg[`RFFQ_LEVEL_MSB:0]}; // RQ19
    rx_nearly_full <= rx_fifo_count >= {1'b0, rx_full_level_reg[`RFFQ_LEVEL_MSB:0]}; // RQ19
  end
end

endmodule // rffq_regs

/* rtl/rffq_consts.vh */
// Purpose: constants for the frequency plan and fifo register group
// Assumes: 7-bit register addresses on the serial bus, 8-bit data
// Notes: included by rffq_regs.v
`ifndef RFFQ_CONSTS_VH
`define RFFQ_CONSTS_VH

// register addresses
`define RFFQ_ADDR_OFFSET_LOW 7'h73
`define RFFQ_ADDR_OFFSET_HIGH 7'h74
`define RFFQ_ADDR_BAND_SELECT 7'h75
`define RFFQ_ADDR_CARRIER_HIGH 7'h76
`define RFFQ_ADDR_CARRIER_LOW 7'h77
`define RFFQ_ADDR_HOP_CHANNEL 7'h79
`define RFFQ_ADDR_HOP_STEP 7'h7a
`define RFFQ_ADDR_TX_FULL_LEVEL 7'h7c
`define RFFQ_ADDR_TX_EMPTY_LEVEL 7'h7d
`define RFFQ_ADDR_RX_FULL_LEVEL 7'h7e
`define RFFQ_ADDR_FIFO_PORT 7'h7f

// reset values
`define RFFQ_RST_OFFSET_LOW 8'h00
`define RFFQ_RST_OFFSET_HIGH 2'h0
`define RFFQ_RST_BAND_SELECT 7'h75
`define RFFQ_RST_CARRIER_HIGH 8'hbb
`define RFFQ_RST_CARRIER_LOW 8'h80
`define RFFQ_RST_HOP_CHANNEL 8'h00
`define RFFQ_RST_HOP_STEP 8'h00
`define RFFQ_RST_TX_FULL_LEVEL 8'h37
`define RFFQ_RST_TX_EMPTY_LEVEL 8'h04
`define RFFQ_RST_RX_FULL_LEVEL 8'h37

// band select fields
`define RFFQ_SIDEBAND_BIT 6
`define RFFQ_HIGHBAND_BIT 5
`define RFFQ_BAND_MSB 4
// level fields
`define RFFQ_LEVEL_MSB 5

// serial frame: first bit is direction, 1 = write
`define RFFQ_DIR_BIT 7
`define RFFQ_BITS_PER_BYTE 3'h7

// carrier arithmetic in kHz: 10000/64000 reduces to 5/32
`define RFFQ_BAND_BASE 24'h000018
`define RFFQ_BAND_KHZ 24'h002710
`define RFFQ_FRAC_MUL 24'sh000005
`define RFFQ_FRAC_SHIFT 5
`define RFFQ_HOP_UNIT_KHZ 24'h00000a
// band start in MHz
`define RFFQ_LOW_START_MHZ 10'h0f0
`define RFFQ_HIGH_START_MHZ 10'h1e0
`define RFFQ_LOW_STEP_MHZ 10'h00a
`define RFFQ_HIGH_STEP_MHZ 10'h014

`endif

/* rtl/rffq_sync.v */
// Purpose: two-stage synchroniser with a third stage for edge finding
// Assumes: inputs are asynchronous to clk
// Notes: only stage two and three are visible outside
`timescale 1ns/100ps
module rffq_sync #(
  parameter WIDTH = 3
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  input wire [WIDTH-1:0] reset_value,
  output wire [WIDTH-1:0] sync_out,
  output wire [WIDTH-1:0] sync_prev
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;
reg [WIDTH-1:0] prev_reg;

always @(posedge clk)
begin
  if (reset)
  begin
    // start at the pins' idle levels so no false select or edge follows reset
    meta_reg <= reset_value;
    sync_reg <= reset_value;
    prev_reg <= reset_value;
  end
  else if (ce)
  begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
    prev_reg <= sync_reg;
  end
end

assign sync_out = sync_reg;
assign sync_prev = prev_reg;

endmodule // rffq_sync

/* tb/rffq_host.sv */
// Purpose: host model driving the serial register bus
// Assumes: mode 0, msb first, 125 ns link clock
// Notes: link clock stands still low between frames
`timescale 1ns/100ps
module rffq_host (
  output reg sclk,
  output reg sdi,
  output reg chip_select_n,
  input wire sdo
);
  initial
  begin
    sclk = 1'b0;
    sdi = 1'b0;
    chip_select_n = 1'b1;
  end
  task open_frame;
  begin
    chip_select_n = 1'b0;
    #100;
  end
  endtask
  task xfer(input [7:0] t, output [7:0] r);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      sdi = t[i];
      #62.5 sclk = 1'b1;
      r[i] = sdo;
      #62.5 sclk = 1'b0;
    end
  end
  endtask
  task close_frame;
  begin
    #100 chip_select_n = 1'b1;
    sdi = ~sdi;
    #200;
  end
  endtask
endmodule // rffq_host

/* tb/rffq_regs_assertions.sv */
// Purpose: port checks for the register group
// Assumes: single clock domain, synchronous reset
// Notes: bound to every rffq_regs instance
`timescale 1ns/100ps
module rffq_regs_chk (
  input wire clk,
  input wire reset,
  input wire chip_select_n,
  input wire sdo,
  input wire sdo_oe,
  input wire tx_fifo_push,
  input wire rx_fifo_pop,
  input wire high_band,
  input wire [9:0] band_start_mhz,
  input wire signed [10:0] offset_steps
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_push_pulse: assert property (tx_fifo_push |=> !tx_fifo_push)
    else $error("push longer than one cycle");
  a_pop_pulse: assert property (rx_fifo_pop |=> !rx_fifo_pop)
    else $error("pop longer than one cycle");
  a_push_framed: assert property (tx_fifo_push |-> sdo_oe)
    else $error("push outside a frame");
  a_pop_framed: assert property (rx_fifo_pop |-> sdo_oe)
    else $error("pop outside a frame");
  a_idle_quiet: assert property (chip_select_n [*4] |-> !sdo_oe && !sdo)
    else $error("sdo active while deselected");
  a_sel_drives: assert property (!chip_select_n [*4] |-> sdo_oe)
    else $error("sdo not enabled while selected");
  a_high_range: assert property (high_band |->
    band_start_mhz >= 10'h1e0 && (band_start_mhz - 10'h1e0) % 10'h014 == 0)
    else $error("high band start wrong");
  a_low_range: assert property (!high_band |->
    band_start_mhz <= 10'h1d6 && band_start_mhz % 10'h00a == 0)
    else $error("low band start wrong");
  a_offset_even: assert property (high_band && $past(high_band) |-> !offset_steps[0])
    else $error("offset not doubled in high band");
  cover property (tx_fifo_push);
  cover property (rx_fifo_pop);
  cover property ($fell(high_band));
endmodule // rffq_regs_chk
bind rffq_regs rffq_regs_chk rffq_regs_chk_inst (.clk(clk), .reset(reset),
  .chip_select_n(chip_select_n), .sdo(sdo), .sdo_oe(sdo_oe), .tx_fifo_push(tx_fifo_push),
  .rx_fifo_pop(rx_fifo_pop), .high_band(high_band), .band_start_mhz(band_start_mhz),
  .offset_steps(offset_steps));

/* tb/rffq_regs_tb.sv */
// Purpose: register and fifo port tests over the serial bus
// Assumes: fifo modelled by the bench around the strobes
// Notes: correction input held at 0x2a5
`timescale 1ns/100ps
module rffq_regs_tb;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [6:0] tx_fifo_count = 7'h00;
  reg [6:0] rx_fifo_count = 7'h00;
  reg tx_fifo_full = 1'b0;
  reg rx_fifo_empty = 1'b1;
  reg [7:0] rx_fifo_data = 8'h3c;
  wire sclk, sdi, chip_select_n, sdo, sdo_oe, tx_fifo_push, rx_fifo_pop, sideband;
  wire tx_nearly_full, tx_nearly_empty, rx_nearly_full, high_band;
  wire [7:0] tx_fifo_data;
  wire [9:0] band_start_mhz;
  wire signed [10:0] offset_steps;
  wire [23:0] carrier_khz;
  integer bad_count = 0;
  integer tests_run = 0;
  integer pushes = 0;
  integer pops = 0;
  reg [15:0] pushed = 16'h0000;
  reg [95:0] rd;
  always #5 clk = ~clk;
  rffq_host rffq_host_inst (.sclk(sclk), .sdi(sdi), .chip_select_n(chip_select_n), .sdo(sdo));
  rffq_regs rffq_regs_inst (.clk(clk), .reset(reset), .ce(1'b1), .sclk(sclk), .sdi(sdi),
    .chip_select_n(chip_select_n), .sdo(sdo), .sdo_oe(sdo_oe), .auto_freq_correction(10'h2a5),
    .tx_fifo_count(tx_fifo_count), .tx_fifo_full(tx_fifo_full), .rx_fifo_count(rx_fifo_count),
    .rx_fifo_empty(rx_fifo_empty), .rx_fifo_data(rx_fifo_data), .tx_fifo_push(tx_fifo_push),
    .tx_fifo_data(tx_fifo_data), .rx_fifo_pop(rx_fifo_pop), .tx_nearly_full(tx_nearly_full),
    .tx_nearly_empty(tx_nearly_empty), .rx_nearly_full(rx_nearly_full), .high_band(high_band),
    .sideband(sideband), .band_start_mhz(band_start_mhz), .offset_steps(offset_steps),
    .carrier_khz(carrier_khz));
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    if (tx_fifo_push === 1'b1)
    begin
      pushed <= {pushed[7:0], tx_fifo_data};
      pushes <= pushes + 1;
    end
    if (rx_fifo_pop === 1'b1)
    begin
      pops <= pops + 1;
      rx_fifo_data <= rx_fifo_data + 8'h01;
    end
  end
  task chk(input [95:0] seen, input [95:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task access(input [7:0] hdr, input integer n, input [95:0] wd);
    reg [7:0] b;
    integer i;
  begin
    rd = 96'h0;
    rffq_host_inst.open_frame;
    rffq_host_inst.xfer(hdr, b);
    for (i = 0; i < n; i = i + 1)
    begin
      rffq_host_inst.xfer(wd[95 - 8 * i -: 8], b);
      rd = {rd[87:0], b};
    end
    rffq_host_inst.close_frame;
    @(posedge clk);
    #1;
  end
  endtask
  task levels(input [6:0] tc, input [6:0] rc, input [2:0] exp);
  begin
    tx_fifo_count = tc;
    rx_fifo_count = rc;
    repeat (3) @(posedge clk);
    #1;
    chk({tx_nearly_full, tx_nearly_empty, rx_nearly_full}, exp);
  end
  endtask
  task wrap_up;
  begin
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  initial
  begin
    #500000;
    bad_count = bad_count + 1;
    wrap_up;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({high_band, sideband, band_start_mhz, carrier_khz}, {2'h3, 10'h384, 24'h0df638});
    access(8'h73, 12, 96'h0);
    chk(rd, 96'ha50275bb8000000000370437);
    access(8'hf3, 12, 96'h40ff920000aa030599c50210);
    access(8'h73, 12, 96'h0);
    chk(rd, 96'ha50212000000030500c50210);
    chk({high_band, sideband, band_start_mhz, offset_steps, carrier_khz},
      {2'h0, 10'h1a4, 11'h740, 24'h066918});
    levels(7'h05, 7'h10, 3'h5);
    levels(7'h02, 7'h0f, 3'h2);
    access(8'hff, 2, {16'h1122, 80'h0});
    chk({pushes[7:0], pushed}, 24'h021122);
    tx_fifo_full = 1'b1;
    access(8'hff, 1, {8'h77, 88'h0});
    chk(pushes, 2);
    rx_fifo_empty = 1'b0;
    access(8'h7f, 2, 96'h0);
    chk({pops[7:0], rd[15:0]}, 24'h023c3d);
    rx_fifo_empty = 1'b1;
    access(8'h7f, 1, 96'h0);
    chk({pops[7:0], rd[7:0]}, 16'h0200);
    wrap_up;
  end
endmodule // rffq_regs_tb
